//--- design/pid_io_signal_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "pid_sel_cfg.svh"

// Operation
// RULE1 - PID runs only for action 20 or 21
// RULE2 - Input selector 14 makes PID enable input
// RULE3 - No enable input: action setting alone decides
// RULE4 - Action 0 or enable off: normal run
// RULE5 - Set point parameter, or terminal when 9999
// RULE6 - Terminal scaled 0-5V or 0-10V by selection
// RULE7 - Measured input scaled 4-20mA, 5V, 10V
// RULE8 - Upper flag when measured exceeds upper limit
// RULE9 - Lower flag when measured below lower limit
// RULE10 - Direction output high for forward rotation
// RULE11 - PID active output on during PID control
// RULE12 - Suspension flag only when detect time valid
// RULE13 - Selector 100 or more inverts output
// RULE14 - Thermistor level set: terminal not set point
// RULE15 - Suspended: running off, PID active on
// RULE16 - Status outputs refreshed every control cycle
module pid_io_signal_select #(
  parameter int N_IN = 5,
  parameter int N_OUT = 3,
  parameter int ADC_W = 12
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // Input terminals and analog codes
  input wire logic [N_IN-1:0] I_IN_TERM,
  input wire logic [ADC_W-1:0] I_SETPT_CODE,
  input wire logic [ADC_W-1:0] I_MEAS_CODE,
  // Drive state
  input wire logic I_FWD_ROT,
  input wire logic I_RUN_REQ,
  input wire logic I_SUSPEND_REQ,
  // Status terminals and results
  output logic [N_OUT-1:0] O_OUT_TERM,
  output logic O_RUN,
  output logic O_PID_ACTIVE,
  output logic [9:0] O_SET_POINT,
  output logic [9:0] O_MEASURED,
  // Interrupt
  output logic O_IRQ
);

  localparam int N_EV = 4;

  function automatic logic [15:0] cfg_rst(input int idx);
    case (idx)
      0: cfg_rst = `CFG_RST_ACTION;
      1: cfg_rst = `CFG_RST_SETPT;
      2: cfg_rst = `CFG_RST_UPLIM;
      3: cfg_rst = `CFG_RST_LOLIM;
      4: cfg_rst = `CFG_RST_AINSEL;
      5: cfg_rst = `CFG_RST_MEASSEL;
      6: cfg_rst = `CFG_RST_SUSPT;
      7: cfg_rst = `CFG_RST_THERM;
      default: cfg_rst = `CFG_RST_SEL;
    endcase
  endfunction

  function automatic logic is_set(input logic [15:0] v);
    is_set = (v != `CFG_VAL_NONE);
  endfunction

  pid_sel_pkg::bus_req_t req;
  logic [15:0] cfg_q [`CFG_NUM_WORDS];
  logic [15:0] cfg_d [`CFG_NUM_WORDS];
  logic [N_EV-1:0] irq_stat_q, irq_stat_d;
  logic [N_EV-1:0] irq_en_q, irq_en_d;
  logic [31:0] rdata_q, rdata_d;
  pid_sel_pkg::status_sig_t sig, sig_q;
  logic run_q, run_d;
  logic [9:0] setpt_q, setpt_d;
  logic [N_EV-1:0] ev;

  logic [15:0] action, setpt_par, uplim, lolim, ainsel, meassel, suspt, therm;
  logic action_pid;
  logic en_assigned;
  logic en_level;
  logic pid_on;
  logic suspend_on;
  logic [9:0] term2_pct, meas_pct;
  pid_sel_pkg::ain_range_t sp_range, meas_range;

  assign req = '{wdata: I_WDATA, addr: I_ADDR, wr: I_WR, rd: I_RD};

  // Register file
  always_comb begin
    for (int i = 0; i < `CFG_NUM_WORDS; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    irq_en_d = irq_en_q;
    if (req.wr && (req.addr[1:0] == 2'b00)) begin
      if (req.addr < `CFG_OFS_STATUS) begin
        cfg_d[req.addr[5:2]] = req.wdata[15:0];
      end else if (req.addr == `CFG_OFS_IRQ_EN) begin
        irq_en_d = req.wdata[N_EV-1:0];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      for (int i = 0; i < `CFG_NUM_WORDS; i++) begin
        cfg_q[i] <= cfg_rst(i);
      end
      irq_en_q <= '0;
    end else begin
      for (int i = 0; i < `CFG_NUM_WORDS; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      irq_en_q <= irq_en_d;
    end
  end

  assign action = cfg_q[`CFG_IDX_ACTION];
  assign setpt_par = cfg_q[`CFG_IDX_SETPT];
  assign uplim = cfg_q[`CFG_IDX_UPLIM];
  assign lolim = cfg_q[`CFG_IDX_LOLIM];
  assign ainsel = cfg_q[`CFG_IDX_AINSEL];
  assign meassel = cfg_q[`CFG_IDX_MEASSEL];
  assign suspt = cfg_q[`CFG_IDX_SUSPT];
  assign therm = cfg_q[`CFG_IDX_THERM];

  // PID enable decision
  always_comb begin
    action_pid = (action == `CFG_VAL_PID_A) || (action == `CFG_VAL_PID_B); // [RULE1]
    en_assigned = 1'b0;
    en_level = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (cfg_q[`CFG_IDX_INSEL0 + 4'(i)] == `CFG_VAL_IN_PID_EN) begin
        en_assigned = 1'b1;
        en_level = en_level | I_IN_TERM[i]; // [RULE2]
      end
    end
    // Unassigned enable leaves the action setting in sole charge
    pid_on = action_pid && (!en_assigned || en_level); // [RULE3] [RULE4]
    // Suspension is only meaningful while PID is actually running
    suspend_on = pid_on && is_set(suspt) && I_SUSPEND_REQ; // [RULE12]
  end

  // Analog ranges
  always_comb begin
    case (ainsel)
      `CFG_VAL_AIN_5V_A, `CFG_VAL_AIN_5V_B: sp_range = pid_sel_pkg::RANGE_0_5V; // [RULE6]
      `CFG_VAL_AIN_10V_A, `CFG_VAL_AIN_10V_B: sp_range = pid_sel_pkg::RANGE_0_10V; // [RULE6]
      default: sp_range = pid_sel_pkg::RANGE_0_10V;
    endcase
    case (meassel)
      `CFG_VAL_MEAS_4_20MA: meas_range = pid_sel_pkg::RANGE_4_20MA; // [RULE7]
      `CFG_VAL_MEAS_5V: meas_range = pid_sel_pkg::RANGE_0_5V; // [RULE7]
      `CFG_VAL_MEAS_10V: meas_range = pid_sel_pkg::RANGE_0_10V; // [RULE7]
      default: meas_range = pid_sel_pkg::RANGE_4_20MA;
    endcase
  end

  pid_pct_scaler #(
    .ADC_W(ADC_W)
  ) u_sp_scale (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_code(I_SETPT_CODE),
    .i_range(sp_range),
    .o_pct(term2_pct)
  );

  pid_pct_scaler #(
    .ADC_W(ADC_W)
  ) u_meas_scale (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_code(I_MEAS_CODE),
    .i_range(meas_range),
    .o_pct(meas_pct)
  );

  // Set point source
  always_comb begin
    if (setpt_par == `CFG_VAL_NONE) begin
      // With thermistor protection the terminal is taken, so no source is left
      setpt_d = is_set(therm) ? 10'h000 : term2_pct; // [RULE5] [RULE14]
    end else if (setpt_par > 16'(`CFG_PCT_FULL)) begin
      setpt_d = `CFG_PCT_FULL;
    end else begin
      setpt_d = setpt_par[9:0]; // [RULE5]
    end
  end

  // Status signals
  always_comb begin
    sig.upper = pid_on && is_set(uplim) && (16'(meas_pct) > uplim); // [RULE8]
    sig.lower = pid_on && is_set(lolim) && (16'(meas_pct) < lolim); // [RULE9]
    sig.dir = I_FWD_ROT; // [RULE10]
    sig.pid_act = pid_on; // [RULE11] [RULE15]
    sig.suspend = suspend_on; // [RULE12]
    run_d = I_RUN_REQ && !suspend_on; // [RULE15]
    ev = {sig.suspend & ~sig_q.suspend, sig.pid_act ^ sig_q.pid_act,
          sig.lower & ~sig_q.lower, sig.upper & ~sig_q.upper};
  end

  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    pid_out_term u_term (
      .i_clk(I_CORE_CLK),
      .i_srst(I_SRST),
      .i_sel(cfg_q[`CFG_IDX_OUTSEL0 + 4'(g)]),
      .i_sig(sig),
      .o_level(O_OUT_TERM[g])
    );
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (req.wr && (req.addr == `CFG_OFS_IRQ_CLR)) begin
      irq_stat_d = irq_stat_d & ~req.wdata[N_EV-1:0];
    end
    irq_stat_d = irq_stat_d | ev;
  end

  // Read port
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (req.rd && (req.addr[1:0] == 2'b00)) begin
      if (req.addr < `CFG_OFS_STATUS) begin
        rdata_d = {16'h0000, cfg_q[req.addr[5:2]]};
      end else begin
        case (req.addr)
          `CFG_OFS_STATUS: rdata_d = {26'h0, run_q, sig_q};
          `CFG_OFS_SETPT_OUT: rdata_d = {22'h0, setpt_q};
          `CFG_OFS_MEAS_OUT: rdata_d = {22'h0, meas_pct};
          `CFG_OFS_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
          `CFG_OFS_IRQ_EN: rdata_d = {28'h0, irq_en_q};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      sig_q <= '0;
      run_q <= 1'b0;
      setpt_q <= 10'h000;
      irq_stat_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      sig_q <= sig; // [RULE16]
      run_q <= run_d;
      setpt_q <= setpt_d;
      irq_stat_q <= irq_stat_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_RUN = run_q;
  assign O_PID_ACTIVE = sig_q.pid_act;
  assign O_SET_POINT = setpt_q;
  assign O_MEASURED = meas_pct;
  assign O_IRQ = |(irq_stat_q & irq_en_q);

endmodule

`default_nettype wire

//--- design/pid_out_term.sv
`timescale 1ns/1ps
`default_nettype none
`include "pid_sel_cfg.svh"

module pid_out_term (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Function select and status
  input wire logic [15:0] i_sel,
  input wire pid_sel_pkg::status_sig_t i_sig,
  // Terminal level
  output logic o_level
);

  logic level_q, level_d;
  logic neg;
  logic [15:0] func;
  logic act;

  always_comb begin
    neg = (i_sel >= `CFG_VAL_OUT_NEG);
    func = neg ? 16'(i_sel - `CFG_VAL_OUT_NEG) : i_sel;
    case (func)
      `CFG_VAL_OUT_UPPER: act = i_sig.upper;
      `CFG_VAL_OUT_LOWER: act = i_sig.lower;
      `CFG_VAL_OUT_DIR: act = i_sig.dir;
      `CFG_VAL_OUT_PID: act = i_sig.pid_act;
      `CFG_VAL_OUT_SUSPEND: act = i_sig.suspend;
      default: act = 1'b0;
    endcase
    level_d = act ^ neg; // [RULE13]
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d; // [RULE16]
    end
  end

  assign o_level = level_q;

endmodule

`default_nettype wire

//--- design/pid_pct_scaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "pid_sel_cfg.svh"

module pid_pct_scaler #(
  parameter int ADC_W = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Converter code and range
  input wire logic [ADC_W-1:0] i_code,
  input wire pid_sel_pkg::ain_range_t i_range,
  // Scaled value
  output logic [9:0] o_pct
);

  localparam logic [ADC_W-1:0] OFS_4MA = ADC_W'((2 ** ADC_W) / 5);

  logic [9:0] pct_q, pct_d;
  logic [ADC_W+15:0] prod;
  logic [ADC_W-1:0] base;

  always_comb begin
    base = i_code;
    prod = '0;
    case (i_range)
      pid_sel_pkg::RANGE_0_10V: begin
        prod = i_code * `CFG_SCALE_10V;
      end
      pid_sel_pkg::RANGE_0_5V: begin
        prod = i_code * `CFG_SCALE_5V;
      end
      pid_sel_pkg::RANGE_4_20MA: begin
        // Below the live-zero offset the reading clamps to 0 %
        base = (i_code > OFS_4MA) ? ADC_W'(i_code - OFS_4MA) : '0;
        prod = base * `CFG_SCALE_4_20MA;
      end
      default: begin
        prod = '0;
      end
    endcase
    if ((prod >> ADC_W) > (ADC_W+16)'(`CFG_PCT_FULL)) begin
      pct_d = `CFG_PCT_FULL;
    end else begin
      pct_d = 10'(prod >> ADC_W);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pct_q <= 10'h000;
    end else begin
      pct_q <= pct_d;
    end
  end

  assign o_pct = pct_q;

endmodule

`default_nettype wire

//--- design/pid_sel_cfg.svh
`ifndef PID_SEL_CFG_SVH
`define PID_SEL_CFG_SVH

// Register byte offsets
`define CFG_OFS_ACTION 8'h00
`define CFG_OFS_SETPT 8'h04
`define CFG_OFS_UPLIM 8'h08
`define CFG_OFS_LOLIM 8'h0C
`define CFG_OFS_AINSEL 8'h10
`define CFG_OFS_MEASSEL 8'h14
`define CFG_OFS_SUSPT 8'h18
`define CFG_OFS_THERM 8'h1C
`define CFG_OFS_INSEL0 8'h20
`define CFG_OFS_OUTSEL0 8'h34
`define CFG_OFS_STATUS 8'h40
`define CFG_OFS_SETPT_OUT 8'h44
`define CFG_OFS_MEAS_OUT 8'h48
`define CFG_OFS_IRQ_STAT 8'h4C
`define CFG_OFS_IRQ_EN 8'h50
`define CFG_OFS_IRQ_CLR 8'h54

// Word indices of the parameter array
`define CFG_IDX_ACTION 4'h0
`define CFG_IDX_SETPT 4'h1
`define CFG_IDX_UPLIM 4'h2
`define CFG_IDX_LOLIM 4'h3
`define CFG_IDX_AINSEL 4'h4
`define CFG_IDX_MEASSEL 4'h5
`define CFG_IDX_SUSPT 4'h6
`define CFG_IDX_THERM 4'h7
`define CFG_IDX_INSEL0 4'h8
`define CFG_IDX_OUTSEL0 4'hD
`define CFG_NUM_WORDS 16

// Reset values
`define CFG_RST_ACTION 16'h0000
`define CFG_RST_SETPT 16'h270F
`define CFG_RST_UPLIM 16'h270F
`define CFG_RST_LOLIM 16'h270F
`define CFG_RST_AINSEL 16'h0001
`define CFG_RST_MEASSEL 16'h0000
`define CFG_RST_SUSPT 16'h0001
`define CFG_RST_THERM 16'h270F
`define CFG_RST_SEL 16'h0000

// Setting values
`define CFG_VAL_NONE 16'h270F
`define CFG_VAL_PID_A 16'h0014
`define CFG_VAL_PID_B 16'h0015
`define CFG_VAL_IN_PID_EN 16'h000E
`define CFG_VAL_AIN_10V_A 16'h0000
`define CFG_VAL_AIN_5V_A 16'h0001
`define CFG_VAL_AIN_10V_B 16'h000A
`define CFG_VAL_AIN_5V_B 16'h000B
`define CFG_VAL_MEAS_4_20MA 16'h0000
`define CFG_VAL_MEAS_5V 16'h0001
`define CFG_VAL_MEAS_10V 16'h0002
`define CFG_VAL_OUT_LOWER 16'h000E
`define CFG_VAL_OUT_UPPER 16'h000F
`define CFG_VAL_OUT_DIR 16'h0010
`define CFG_VAL_OUT_PID 16'h002F
`define CFG_VAL_OUT_SUSPEND 16'h0046
`define CFG_VAL_OUT_NEG 16'h0064

// Percent scale, 0.1 % steps
`define CFG_PCT_FULL 10'h3E8
`define CFG_SCALE_10V 16'h03E8
`define CFG_SCALE_5V 16'h07D0
`define CFG_SCALE_4_20MA 16'h04E2

`endif

//--- design/pid_sel_pkg.sv
package pid_sel_pkg;

  typedef enum logic [1:0] {
    RANGE_0_10V,
    RANGE_0_5V,
    RANGE_4_20MA
  } ain_range_t;

  typedef struct packed {
    logic suspend;
    logic pid_act;
    logic dir;
    logic lower;
    logic upper;
  } status_sig_t;

  typedef struct packed {
    logic [31:0] wdata;
    logic [7:0] addr;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

//--- test/pid_io_signal_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pid_sel_chk #(
  parameter int N_IN = 5,
  parameter int ADC_W = 12
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic [N_IN-1:0] I_IN_TERM,
  input wire logic [ADC_W-1:0] I_MEAS_CODE,
  input wire logic I_RUN_REQ,
  input wire logic I_SUSPEND_REQ,
  input wire logic O_RUN,
  input wire logic O_PID_ACTIVE,
  input wire logic [9:0] O_SET_POINT,
  input wire logic [9:0] O_MEASURED,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  property p_rdata_idle;
    O_RDATA != 32'h0 |-> $past(I_RD);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_run_cause;
    O_RUN |-> $past(I_RUN_REQ);
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("run without request");
  // Only suspension may drop a requested run, and it keeps PID on
  property p_suspend_run;
    !$past(I_SRST) && $past(I_RUN_REQ) && !O_RUN |-> O_PID_ACTIVE && $past(I_SUSPEND_REQ);
  endproperty
  a_suspend_run: assert property (p_suspend_run) else $error("run dropped wrongly");
  property p_sp_max;
    O_SET_POINT <= 10'h3E8;
  endproperty
  a_sp_max: assert property (p_sp_max) else $error("set point above full scale");
  property p_meas_max;
    O_MEASURED <= 10'h3E8;
  endproperty
  a_meas_max: assert property (p_meas_max) else $error("measured above full scale");
  property p_pid_steady;
    !$past(I_SRST) && !$past(I_WR) && $stable(I_IN_TERM) |=> $stable(O_PID_ACTIVE);
  endproperty
  a_pid_steady: assert property (p_pid_steady) else $error("pid active moved alone");
  property p_meas_steady;
    !$past(I_SRST) && !$past(I_WR) && !$past(I_WR, 2) && $stable(I_MEAS_CODE) |=> $stable(O_MEASURED);
  endproperty
  a_meas_steady: assert property (p_meas_steady) else $error("measured moved alone");
  property p_rst_quiet;
    $past(I_SRST) |-> !O_RUN && !O_PID_ACTIVE && !O_IRQ && O_MEASURED == 10'h000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
  c_susp: cover property (O_PID_ACTIVE && !O_RUN);
  c_irq: cover property (O_IRQ);
  c_read: cover property (O_RDATA != 32'h0);
endmodule
bind pid_io_signal_select pid_sel_chk #(.N_IN(N_IN), .ADC_W(ADC_W)) chk (.I_CORE_CLK(I_CORE_CLK),
  .I_SRST(I_SRST), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_IN_TERM(I_IN_TERM),
  .I_MEAS_CODE(I_MEAS_CODE), .I_RUN_REQ(I_RUN_REQ), .I_SUSPEND_REQ(I_SUSPEND_REQ), .O_RUN(O_RUN),
  .O_PID_ACTIVE(O_PID_ACTIVE), .O_SET_POINT(O_SET_POINT), .O_MEASURED(O_MEASURED), .O_IRQ(O_IRQ));
`default_nettype wire

//--- test/status_reader.sv
`timescale 1ns/1ps
`default_nettype none
module status_reader (
  // Clock
  input wire logic i_clk,
  // Drive terminals
  input wire logic [2:0] i_term,
  // Levels as the controller latched them
  output logic [2:0] o_seen
);
  // One scan of delay, like an outside controller input stage
  always_ff @(posedge i_clk) o_seen <= i_term;
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int NONE = 16'h270F;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fwd = 1'b0, run = 1'b0, sus = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [4:0] in_t = 5'h00;
  logic [11:0] spc = 12'h000, mc = 12'h000;
  logic [2:0] term, seen;
  logic o_run, o_pid, irq;
  logic [9:0] o_sp, o_meas;
  int bad_count = 0, comparisons = 0, lf = 31;
  int cfg[16] = '{0, NONE, NONE, NONE, 1, 0, 1, NONE, 0, 0, 0, 0, 0, 0, 0, 0};
  int acts[4] = '{0, 20, 21, 19};
  int ains[4] = '{0, 1, 10, 11};
  always #5 clk = ~clk;
  pid_io_signal_select uut (.I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_IN_TERM(in_t), .I_SETPT_CODE(spc), .I_MEAS_CODE(mc), .I_FWD_ROT(fwd),
    .I_RUN_REQ(run), .I_SUSPEND_REQ(sus), .O_OUT_TERM(term), .O_RUN(o_run), .O_PID_ACTIVE(o_pid),
    .O_SET_POINT(o_sp), .O_MEASURED(o_meas), .O_IRQ(irq));
  status_reader rdr (.i_clk(clk), .i_term(term), .o_seen(seen));
  function automatic int rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic int sc(int c, int m);
    int v = m == 0 ? c * 1000 >> 12 : m == 1 ? c * 2000 >> 12 : c < 819 ? 0 : (c - 819) * 1250 >> 12;
    return v > 1000 ? 1000 : v;
  endfunction
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (e !== s) begin
      bad_count++;
      $display("BAD %s exp %0d got %0d", n, e, s);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 8'h40) cfg[a >> 2] = v;
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  // Settles all paths, then compares every result except the interrupt with the model
  task automatic check();
    int en, hit, on, mv, sp, f;
    logic [5:0] st;
    en = 0;
    hit = 0;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 5; i++) if (cfg[8 + i] == 14) begin
      en = 1;
      hit |= in_t[i];
    end
    on = (cfg[0] == 20 || cfg[0] == 21) && (!en || hit);
    mv = sc(mc, cfg[5] == 1 ? 1 : cfg[5] == 2 ? 0 : 2);
    sp = cfg[1] != NONE ? (cfg[1] > 1000 ? 1000 : cfg[1]) : cfg[7] != NONE ? 0 : sc(spc, cfg[4] % 10 == 1);
    st[0] = on && cfg[2] != NONE && mv > cfg[2];
    st[1] = on && cfg[3] != NONE && mv < cfg[3];
    st[2] = fwd;
    st[3] = on;
    st[4] = on && sus && cfg[6] != NONE;
    st[5] = run && !st[4];
    for (int i = 0; i < 3; i++) begin
      f = cfg[13 + i] % 100;
      f = f == 15 ? st[0] : f == 14 ? st[1] : f == 16 ? st[2] : f == 47 ? st[3] : f == 70 ? st[4] : 0;
      cmp("term", f ^ (cfg[13 + i] >= 100), seen[i]);
    end
    cmp("pid", on, o_pid);
    cmp("run", st[5], o_run);
    cmp("meas", mv, o_meas);
    cmp("setpt", sp, o_sp);
    rreg(8'h40, d);
    cmp("status", st, d);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rreg(8'(i * 4), d);
      cmp("reset", cfg[i], d);
    end
    rreg(8'h80, d);
    cmp("unmapped", 0, d);
    wreg(8'h34, 47);
    wreg(8'h38, 147);
    wreg(8'h3C, 116);
    foreach (acts[k]) begin
      for (int m = 0; m < 4; m++) begin
        wreg(8'h00, acts[k]);
        wreg(8'h30, m[1] ? 14 : 0);
        @(posedge clk);
        in_t <= {m[0], 4'(rnd())};
        fwd <= 1'(rnd());
        run <= 1'(rnd());
        check();
      end
    end
    wreg(8'h00, 20);
    wreg(8'h30, 0);
    wreg(8'h34, 15);
    wreg(8'h38, 114);
    wreg(8'h08, 500);
    wreg(8'h0C, 200);
    for (int j = 0; j < 12; j++) begin
      wreg(8'h14, j % 3);
      wreg(8'h10, ains[j % 4]);
      wreg(8'h04, j == 9 ? 1500 : j == 10 ? 300 : NONE);
      wreg(8'h1C, j == 7 ? 50 : NONE);
      @(posedge clk);
      mc <= 12'(rnd());
      spc <= 12'(rnd());
      check();
    end
    wreg(8'h34, 70);
    wreg(8'h38, 170);
    wreg(8'h18, 10);
    wreg(8'h50, 8);
    @(posedge clk);
    sus <= 1'b1;
    run <= 1'b1;
    check();
    cmp("irq", 1, irq);
    rreg(8'h4C, d);
    cmp("irqstat", 1, d[3]);
    cmp("irqpid", 1, d[2]);
    wreg(8'h54, 15);
    #1 cmp("irq", 0, irq);
    rreg(8'h54, d);
    cmp("clrread", 0, d);
    wreg(8'h18, NONE);
    check();
    tally_and_finish();
  end
endmodule
`default_nettype wire
